// ---- sim/gftd_sensor_model.sv ----
// flowmeter and transmitter model: pulse frequency, two 4-20 mA dp codes, pressure
// assumes the bench sets levels in Q16 units; temperature and compressibility held at base
`timescale 1ns/1ps
module gftd_sensor_model (
  input wire logic [31:0] freqSet,
  input wire logic [31:0] ma1,
  input wire logic [31:0] ma2,
  input wire logic [31:0] pressSet,
  output wire gftd_pkg::gftd_sensor_t sensors
);
  // ==========================================================
  // adc front end
  // codes above 20 mA keep rising, as an overdriven transmitter does
  function automatic logic [15:0] toCode(input logic [31:0] ma);
    return gftd_pkg::I4_CODE + 16'((64'(ma - 32'h40000) * 64'(gftd_pkg::ISPAN_CODE)) >> 20);
  endfunction : toCode

  assign sensors = {freqSet, toCode(ma1), toCode(ma2), gftd_pkg::STD_T_SI, pressSet, gftd_pkg::Q_ONE};
endmodule : gftd_sensor_model

// ---- sim/gftd_totalizer_sva.sv ----
// port checker for the totaliser: read port, keys, display timeout, pulse shape
// assumes one clock and the shortened counts handed on by the bind
`timescale 1ns/1ps
module gftd_totalizer_sva #(
  parameter int TimeoutCyc = gftd_pkg::TIMEOUT_CYC,
  parameter int PulseCyc = gftd_pkg::PULSE_CYC,
  parameter int GapCyc = gftd_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire gftd_pkg::gftd_keys_t keys,
  input wire logic [1:0] displayItem,
  input wire logic displayTotal,
  input wire logic [26:0] defaultTotal,
  input wire logic pulseOutN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // helper counters
  logic [31:0] lowCnt, highCnt, quietCnt;
  logic [1:0] prevItem;
  always_ff @(posedge clk) begin
    if (!rst_n || pulseOutN) lowCnt <= '0;
    else lowCnt <= lowCnt + 1;
  end
  // saturates so a long idle never wraps back under the gap
  always_ff @(posedge clk) begin
    if (!rst_n || !pulseOutN) highCnt <= '0;
    else if (highCnt != '1) highCnt <= highCnt + 1;
  end
  always_ff @(posedge clk) begin
    prevItem <= rst_n ? displayItem : 2'h0;
    if (!rst_n || keys != '0 || displayItem != prevItem) quietCnt <= '0;
    else quietCnt <= quietCnt + 1;
  end
  // ==========================================================
  // properties
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  pulse_width_a: assert property ($rose(pulseOutN) |-> lowCnt == PulseCyc)
    else $error("scaled pulse width wrong");
  pulse_gap_a: assert property ($fell(pulseOutN) |-> highCnt >= GapCyc)
    else $error("scaled pulse gap too short");
  total_range_a: assert property (defaultTotal < gftd_pkg::TOTAL_WRAP)
    else $error("total beyond eight digits");
  disp_step_a: assert property (keys == 4'h2 |=> displayItem != $past(displayItem))
    else $error("display key did not advance");
  rate_view_a: assert property (keys.rateKey |=> !displayTotal)
    else $error("rate key did not show a rate");
  total_view_a: assert property (keys == 4'h4 |=> displayTotal)
    else $error("total key did not show a total");
  reset_refuse_a: assert property (keys.resetKey && !displayTotal |=> defaultTotal >= $past(defaultTotal))
    else $error("reset acted while a rate was shown");
  view_timeout_a: assert property (displayItem != prevItem && $past(keys) == '0 |->
    quietCnt >= TimeoutCyc - 3 && quietCnt <= TimeoutCyc + 2) else $error("display reverted at wrong time");
endmodule : gftd_totalizer_sva

bind gftd_totalizer gftd_totalizer_sva #(.TimeoutCyc(TimeoutCyc), .PulseCyc(PulseCyc), .GapCyc(GapCyc))
  gftd_totalizer_sva_i (.clk(clk), .rst_n(rst_n), .regRd(regRd), .regRdata(regRdata), .keys(keys),
  .displayItem(displayItem), .displayTotal(displayTotal), .defaultTotal(defaultTotal), .pulseOutN(pulseOutN));

// ---- sim/tb_top.sv ----
// testbench: registers, rate equations, crossover, totals, pulses and display keys
// assumes the totaliser with shortened counts and the sensor model on its far side
`timescale 1ns/1ps
module tb_top;
  localparam int ToC = 200;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, rdPend = 0;
  logic [7:0] regAddr = '0;
  logic [31:0] regWdata = '0, fHz = '0, ma1 = 32'h40000, ma2 = 32'h40000, pAbs = gftd_pkg::STD_P_SI, r;
  logic [31:0] regRdata, defaultRate;
  logic [31:0] maTab[3] = '{32'h140000, 32'h148000, 32'hc0000};
  logic [31:0] expTab[3] = '{32'h10000, 32'h30000, 32'h8000};
  gftd_pkg::gftd_sensor_t sensors;
  gftd_pkg::gftd_keys_t keys = '0;
  logic [1:0] displayItem;
  logic displayTotal, alarmHigh, alarmLow, pulseOutN;
  logic [26:0] defaultTotal, t0;
  logic [31:0] expQ[$], tolQ[$];
  int failures = 0, checked = 0, pulses = 0, cyc = 0;

  always #12.5 clk = ~clk;

  gftd_totalizer #(.TimeoutCyc(ToC), .UpdateCyc(50), .PulseCyc(5), .GapCyc(6)) gftd_totalizer_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sensors(sensors), .steamMassRate(fHz), .steamEnergyRate(ma1), .keys(keys),
    .displayItem(displayItem), .displayTotal(displayTotal), .defaultRate(defaultRate),
    .defaultTotal(defaultTotal), .alarmHigh(alarmHigh), .alarmLow(alarmLow), .pulseOutN(pulseOutN));
  gftd_sensor_model gftd_sensor_model_i (.freqSet(fHz), .ma1(ma1), .ma2(ma2), .pressSet(pAbs), .sensors(sensors));

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    checked++;
    // an unknown result makes the compare unknown, which counts as a miss
    if ((got + tol - exp <= tol * 2) !== 1'b1) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if ($fell(pulseOutN)) pulses++;
    if (rdPend) chk(regRdata, expQ.pop_front(), tolQ.pop_front());
    rdPend <= regRd;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================
  // drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] tol);
    expQ.push_back(e);
    tolQ.push_back(tol);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic key(input gftd_pkg::gftd_keys_t k);
    keys <= k;
    @(posedge clk);
    keys <= '0;
    repeat (2) @(posedge clk);
  endtask : key

  initial begin
    void'($urandom(32'h16b1));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h00, 32'h0, 0);
    rd(8'h20, 32'h0, 0);
    rd(8'h15, gftd_pkg::Q_ONE, 32'h10);
    for (int i = 0; i < 2; i++) begin
      r = $urandom;
      wr(8'(8 + i), r);
      rd(8'(8 + i), r, 0);
    end
    wr(8'h01, 32'h20000);
    fHz <= 32'ha0000;
    pAbs <= 32'h00caa666;
    wr(8'h08, 32'h10000);
    repeat (8) @(posedge clk);
    rd(8'h10, 32'ha0000, 32'h200);
    rd(8'h11, 32'hc3fc0, 32'h200);
    chk(defaultRate, 32'ha0000, 32'h200);
    chk({31'h0, alarmHigh}, 32'h1, 0);
    chk({31'h0, alarmLow}, {31'h0, r > 32'ha0000}, 0);
    wr(8'h00, 32'h1);
    ma1 <= 32'h140000;
    repeat (8) @(posedge clk);
    rd(8'h10, 32'h10000, 32'h200);
    wr(8'h00, 32'h103);
    wr(8'h02, 32'h30000);
    pAbs <= gftd_pkg::STD_P_SI;
    for (int i = 0; i < 3; i++) begin
      ma2 <= maTab[i];
      repeat (8) @(posedge clk);
      rd(8'h10, expTab[i], 32'h200);
    end
    wr(8'h00, 32'h102);
    repeat (8) @(posedge clk);
    rd(8'h10, 32'hb505, 32'h200);
    wr(8'h00, 32'h81);
    repeat (8) @(posedge clk);
    rd(8'h10, 32'h272fd, 32'h200);
    rd(8'h16, 32'h13993, 32'h100);
    wr(8'h00, 32'h0);
    wr(8'h01, 32'h10000);
    for (int i = 0; i < 2; i++) begin
      fHz <= i ? 32'h4e200000 : 32'h140000;
      repeat (60) @(posedge clk);
      t0 = defaultTotal;
      repeat (500) @(posedge clk);
      chk(32'(defaultTotal - t0), 32'h14, 0);
      wr(8'h00, 32'h20);
    end
    // let the pending pulses drain before counting them
    fHz <= '0;
    repeat (1500) @(posedge clk);
    chk(32'(pulses), 32'(defaultTotal), 0);
    wr(8'h00, 32'h40);
    key(4'h4);
    t0 = defaultTotal;
    key(4'h1);
    chk(32'(defaultTotal), 32'(t0), 0);
    wr(8'h00, 32'h0);
    key(4'h8);
    key(4'h1);
    chk(32'(defaultTotal), 32'(t0), 0);
    key(4'h4);
    chk({29'h0, displayTotal, displayItem}, 32'h4, 0);
    key(4'h1);
    rd(8'h12, 32'h0, 0);
    rd(8'h13, 32'h0, 0);
    key(4'h8);
    for (int i = 1; i < 5; i++) begin
      key(4'h2);
      chk({30'h0, displayItem}, 32'(i % 3), 0);
    end
    repeat (ToC - 6) @(posedge clk);
    chk({30'h0, displayItem}, 32'h1, 0);
    repeat (10) @(posedge clk);
    chk({30'h0, displayItem}, 32'h0, 0);
    wr(8'h00, 32'h10);
    key(4'h8);
    chk({30'h0, displayItem}, 32'h1, 0);
    wr(8'h00, 32'h8);
    rd(8'h11, 32'h140000, 0);
    key(4'h8);
    repeat (3) key(4'h2);
    chk({30'h0, displayItem}, 32'h3, 0);
    wr(8'h00, 32'h4004);
    rd(8'h06, 32'heb22a, 32'h2);
    print_verdict();
  end
endmodule : tb_top

// ---- src/gftd_pkg.sv ----
// shared constants, register map and carrier types for the gas flow totaliser
// assumes one 40 MHz clock and unsigned Q16.16 arithmetic throughout
package gftd_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_S = 5;
  localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int UPDATE_MS = 100;
  localparam int UPDATE_CYC = UPDATE_MS * (CLK_HZ / 1000);
  localparam int UPDATE_PER_S = 1000 / UPDATE_MS;
  localparam int PULSE_MS = 10;
  localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int GAP_MS = 11;
  localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);

  // ==========================================================
  // numeric constants, Q16.16 apart from the total wrap, ADC codes and x1000 divider
  localparam logic [31:0] Q_ONE = 32'h00010000;
  localparam logic [31:0] AIR_MW = 32'h001cf666;
  localparam logic [31:0] DENS_SI = 32'h00037bc0;
  localparam logic [31:0] DENS_US = 32'h0002b2e5;
  localparam logic [31:0] STD_T_SI = 32'h01202666;
  localparam logic [31:0] STD_P_SI = 32'h00655333;
  localparam logic [31:0] STD_T_US = 32'h0206ab85;
  localparam logic [31:0] STD_P_US = 32'h000eb22a;
  localparam logic [26:0] TOTAL_WRAP = 27'h5f5e100;
  localparam logic [15:0] I4_CODE = 16'h28f6;
  localparam logic [15:0] I20_CODE = 16'hcccc;
  localparam logic [15:0] ISPAN_CODE = 16'ha3d6;
  localparam logic [31:0] X1000_DIV = 32'h000003e8;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_KFACTOR = 8'h01;
  localparam logic [7:0] REG_SPAN1 = 8'h02;
  localparam logic [7:0] REG_SPAN2 = 8'h03;
  localparam logic [7:0] REG_MOLWT = 8'h04;
  localparam logic [7:0] REG_BASE_T = 8'h05;
  localparam logic [7:0] REG_BASE_P = 8'h06;
  localparam logic [7:0] REG_BASE_Z = 8'h07;
  localparam logic [7:0] REG_ALARM_HI = 8'h08;
  localparam logic [7:0] REG_ALARM_LO = 8'h09;
  localparam logic [7:0] REG_RATE0 = 8'h10;
  localparam logic [7:0] REG_RATE1 = 8'h11;
  localparam logic [7:0] REG_TOTAL0 = 8'h12;
  localparam logic [7:0] REG_TOTAL1 = 8'h13;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SG = 8'h15;
  localparam logic [7:0] REG_DENSITY = 8'h16;
  localparam int CFG_LOAD_STD_BIT = 14;
  localparam logic [13:0] CFG_RESET = 14'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {METER_FREQ, METER_AVOL, METER_DPSQ, METER_DPLIN} gftd_meter_t;
  typedef enum logic [1:0] {ITEM_Q0, ITEM_Q1, ITEM_TP, ITEM_SWH} gftd_item_t;
  typedef enum logic [1:0] {PULSE_IDLE, PULSE_LOW, PULSE_GAP} gftd_pulse_t;

  typedef struct packed {
    logic [1:0] timebase;
    logic [2:0] decimals;
    logic dualTx;
    logic spanIsMass;
    logic resetDisable;
    logic totalX1000;
    logic defaultQty;
    logic steam;
    logic usUnits;
    logic [1:0] meterType;
  } gftd_cfg_t;

  typedef struct packed {
    logic [31:0] freqHz;
    logic [15:0] flow1Code;
    logic [15:0] flow2Code;
    logic [31:0] tempAbs;
    logic [31:0] pressAbs;
    logic [31:0] zRatio;
  } gftd_sensor_t;

  typedef struct packed {
    logic rateKey;
    logic totalKey;
    logic dispKey;
    logic resetKey;
  } gftd_keys_t;

endpackage : gftd_pkg

// ---- src/gftd_totalizer.sv ----
// gas flow totaliser: compensated rates, 8-digit totals, display keys, scaled pulse
// assumes key inputs are debounced one-cycle pulses and sensor words are synchronous
//
// Overview of operation
// - a configurable default quantity; rate and total keys show its rate and total
// - pulse and alarms follow only the default quantity
// - display key steps cyclically through the viewable items of gas or steam
// - a non-default item reverts to the default after 5 seconds on screen
// - totals hold 8 decimal digits and wrap to zero, then keep counting
// - times-1000 total units integrate at one thousandth of the rate
// - reset key works only while a total is shown and clears both totals
// - a configuration bit disables the reset key
// - dual transmitters: use 2 at low flow, 1 once 2 exceeds 20 mA
// - analogue flow input is normalised to the range 0 to 1
// - frequency meter: f/K times pressure, temperature, compressibility ratios
// - analogue volumetric: span times temperature and compressibility ratios times input
// - square-law DP: span times square roots of ratios and of the input
// - linear DP: ratios square-rooted, input applied linearly
// - specific gravity is molecular weight over 28.9625
// - base density from 3.4834 or 2.6988 times SG, base pressure, over ZB TB
// - a span entered as mass is divided by base density
// - standard base is 15 C, 101.325 kPa or 59 F, 14.69595 psia
// - one 10 ms low pulse per least-significant advance of the default total
`timescale 1ns/1ps

module gftd_totalizer #(
  parameter int TimeoutCyc = gftd_pkg::TIMEOUT_CYC,
  parameter int UpdateCyc = gftd_pkg::UPDATE_CYC,
  parameter int PulseCyc = gftd_pkg::PULSE_CYC,
  parameter int GapCyc = gftd_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire gftd_pkg::gftd_sensor_t sensors,
  input wire logic [31:0] steamMassRate,
  input wire logic [31:0] steamEnergyRate,
  input wire gftd_pkg::gftd_keys_t keys,
  output logic [1:0] displayItem,
  output logic displayTotal,
  output logic [31:0] defaultRate,
  output logic [26:0] defaultTotal,
  output logic alarmHigh,
  output logic alarmLow,
  output logic pulseOutN
);

  // ==========================================================
  // fixed-point helpers
  function automatic logic [31:0] mulq(input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    p = 64'(a) * 64'(b);
    return p[47:16];
  endfunction : mulq

  function automatic logic [31:0] divq(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] q;
    q = 48'hffffffffffff;
    if (b != 32'h0) begin
      q = {a, 16'h0} / 48'(b);
    end
    return q[31:0];
  endfunction : divq

  // bitwise root of a Q16 value, result stays Q16
  function automatic logic [31:0] sqrtq(input logic [31:0] x);
    logic [47:0] v;
    logic [23:0] r;
    logic [23:0] t;
    v = {x, 16'h0};
    r = 24'h0;
    for (int i = 23; i >= 0; i--) begin
      t = r | (24'h1 << i);
      if (48'(t) * 48'(t) <= v) begin
        r = t;
      end
    end
    return {8'h0, r};
  endfunction : sqrtq

  function automatic logic [31:0] normq(input logic [15:0] code);
    logic [31:0] n;
    n = 32'h0;
    if (code >= gftd_pkg::I20_CODE) begin
      n = gftd_pkg::Q_ONE;
    end else if (code > gftd_pkg::I4_CODE) begin
      n = 32'({16'h0, code - gftd_pkg::I4_CODE, 16'h0} / {16'h0, gftd_pkg::ISPAN_CODE});
    end
    return n;
  endfunction : normq

  function automatic logic [31:0] pow10(input logic [2:0] d);
    logic [31:0] p;
    case (d)
      3'h0: p = 32'h1;
      3'h1: p = 32'ha;
      3'h2: p = 32'h64;
      3'h3: p = 32'h3e8;
      3'h4: p = 32'h2710;
      3'h5: p = 32'h186a0;
      3'h6: p = 32'hf4240;
      default: p = 32'h989680;
    endcase
    return p;
  endfunction : pow10

  function automatic logic [31:0] tbSec(input logic [1:0] tb);
    logic [31:0] s;
    case (tb)
      2'h0: s = 32'h1;
      2'h1: s = 32'h3c;
      2'h2: s = 32'he10;
      default: s = 32'h15180;
    endcase
    return s;
  endfunction : tbSec

  // ==========================================================
  // configuration registers
  gftd_pkg::gftd_cfg_t cfgReg;
  logic [31:0] kFactorReg, span1Reg, span2Reg, molWtReg;
  logic [31:0] baseTReg, basePReg, baseZReg, alarmHiReg, alarmLoReg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgReg <= gftd_pkg::CFG_RESET;
      kFactorReg <= gftd_pkg::Q_ONE;
      span1Reg <= gftd_pkg::Q_ONE;
      span2Reg <= gftd_pkg::Q_ONE;
      molWtReg <= gftd_pkg::AIR_MW;
      baseTReg <= gftd_pkg::STD_T_SI;
      basePReg <= gftd_pkg::STD_P_SI;
      baseZReg <= gftd_pkg::Q_ONE;
      alarmHiReg <= 32'hffffffff;
      alarmLoReg <= 32'h0;
    end else if (regWr) begin
      case (regAddr)
        gftd_pkg::REG_CFG: begin
          cfgReg <= regWdata[13:0];
          // load standard base for the unit system being written
          if (regWdata[gftd_pkg::CFG_LOAD_STD_BIT]) begin
            baseTReg <= regWdata[2] ? gftd_pkg::STD_T_US : gftd_pkg::STD_T_SI;
            basePReg <= regWdata[2] ? gftd_pkg::STD_P_US : gftd_pkg::STD_P_SI;
          end
        end
        gftd_pkg::REG_KFACTOR: kFactorReg <= regWdata;
        gftd_pkg::REG_SPAN1: span1Reg <= regWdata;
        gftd_pkg::REG_SPAN2: span2Reg <= regWdata;
        gftd_pkg::REG_MOLWT: molWtReg <= regWdata;
        gftd_pkg::REG_BASE_T: baseTReg <= regWdata;
        gftd_pkg::REG_BASE_P: basePReg <= regWdata;
        gftd_pkg::REG_BASE_Z: baseZReg <= regWdata;
        gftd_pkg::REG_ALARM_HI: alarmHiReg <= regWdata;
        gftd_pkg::REG_ALARM_LO: alarmLoReg <= regWdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // flow equations, recomputed every cycle in a short register chain
  logic [31:0] sgReg, rhoBReg, pRatioReg, tRatioReg, aNormReg, spanReg;
  logic [31:0] spanVolReg, cvRateReg, massRateReg;
  logic [31:0] densK, ratio3, aSel, spanSel;
  logic useTx1;

  assign densK = cfgReg.usUnits ? gftd_pkg::DENS_US : gftd_pkg::DENS_SI;
  // transmitter 2 covers low flow until it runs past its top of range
  assign useTx1 = !cfgReg.dualTx || (sensors.flow2Code > gftd_pkg::I20_CODE);
  assign aSel = useTx1 ? normq(sensors.flow1Code) : normq(sensors.flow2Code);
  assign spanSel = useTx1 ? span1Reg : span2Reg;
  assign ratio3 = mulq(mulq(pRatioReg, tRatioReg), sensors.zRatio);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sgReg <= 32'h0;
      rhoBReg <= 32'h0;
      pRatioReg <= 32'h0;
      tRatioReg <= 32'h0;
      aNormReg <= 32'h0;
      spanReg <= 32'h0;
    end else begin
      sgReg <= divq(molWtReg, gftd_pkg::AIR_MW);
      rhoBReg <= divq(mulq(mulq(densK, sgReg), basePReg), mulq(baseZReg, baseTReg));
      pRatioReg <= divq(sensors.pressAbs, basePReg);
      tRatioReg <= divq(baseTReg, sensors.tempAbs);
      aNormReg <= aSel;
      spanReg <= spanSel;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spanVolReg <= 32'h0;
      cvRateReg <= 32'h0;
      massRateReg <= 32'h0;
    end else begin
      spanVolReg <= cfgReg.spanIsMass ? divq(spanReg, rhoBReg) : spanReg;
      case (gftd_pkg::gftd_meter_t'(cfgReg.meterType))
        gftd_pkg::METER_FREQ: // frequency path is per second, scaled to the timebase
          cvRateReg <= 32'(64'(mulq(divq(sensors.freqHz, kFactorReg), ratio3)) *
                           64'(tbSec(cfgReg.timebase)));
        gftd_pkg::METER_AVOL:
          cvRateReg <= mulq(mulq(mulq(spanVolReg, tRatioReg), sensors.zRatio), aNormReg);
        gftd_pkg::METER_DPSQ:
          cvRateReg <= mulq(mulq(spanVolReg, sqrtq(ratio3)), sqrtq(aNormReg));
        default:
          cvRateReg <= mulq(mulq(spanVolReg, sqrtq(ratio3)), aNormReg);
      endcase
      massRateReg <= mulq(rhoBReg, cvRateReg);
    end
  end

  // ==========================================================
  // quantities, default selection, alarms
  logic [31:0] qRate [2];
  logic [31:0] defRate;

  assign qRate[0] = cfgReg.steam ? steamMassRate : cvRateReg;
  assign qRate[1] = cfgReg.steam ? steamEnergyRate : massRateReg;
  assign defRate = cfgReg.defaultQty ? qRate[1] : qRate[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      defaultRate <= 32'h0;
      alarmHigh <= 1'b0;
      alarmLow <= 1'b0;
    end else begin
      defaultRate <= defRate;
      alarmHigh <= defRate > alarmHiReg;
      alarmLow <= defRate < alarmLoReg;
    end
  end

  // ==========================================================
  // update tick and totals
  logic [31:0] updCntReg;
  logic tick;
  logic clearTotals;
  logic [63:0] incDen;
  logic [26:0] totalReg [2];
  logic [15:0] fracReg [2];
  logic [15:0] advance [2];

  assign tick = (updCntReg == 32'(UpdateCyc - 1));
  // x1000 divides the integration rate, not the displayed rate
  assign incDen = 64'(tbSec(cfgReg.timebase)) * 64'(gftd_pkg::UPDATE_PER_S) *
                  64'(cfgReg.totalX1000 ? gftd_pkg::X1000_DIV : 32'h1);

  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      updCntReg <= 32'h0;
    end else begin
      updCntReg <= updCntReg + 32'h1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gTotal
    logic [63:0] inc, sum;
    logic [27:0] tSum;
    logic [26:0] totalNext;
    assign inc = (64'(qRate[g]) * 64'(pow10(cfgReg.decimals))) / incDen;
    assign sum = 64'(fracReg[g]) + inc;
    // one tick is assumed to carry far less than the 8-digit range
    assign tSum = 28'(totalReg[g]) + 28'(sum[42:16]);
    assign totalNext = (tSum >= 28'(gftd_pkg::TOTAL_WRAP)) ?
                       27'(tSum - 28'(gftd_pkg::TOTAL_WRAP)) : tSum[26:0];
    assign advance[g] = tick ? ((sum[63:16] > 48'hffff) ? 16'hffff : sum[31:16]) : 16'h0;

    always_ff @(posedge clk) begin
      if (!rst_n || clearTotals) begin
        totalReg[g] <= 27'h0;
        fracReg[g] <= 16'h0;
      end else if (tick) begin
        totalReg[g] <= totalNext;
        fracReg[g] <= sum[15:0];
      end
    end
  end

  assign defaultTotal = cfgReg.defaultQty ? totalReg[1] : totalReg[0];

  // ==========================================================
  // display item selection and timeout
  gftd_pkg::gftd_item_t itemReg, itemNext, defItem;
  logic showTotalReg;
  logic [31:0] dispTimerReg;
  logic timedOut;

  assign defItem = cfgReg.defaultQty ? gftd_pkg::ITEM_Q1 : gftd_pkg::ITEM_Q0;
  assign timedOut = (itemReg != defItem) && (dispTimerReg == 32'(TimeoutCyc - 1));

  always_comb begin
    case (itemReg)
      gftd_pkg::ITEM_Q0: itemNext = gftd_pkg::ITEM_Q1;
      gftd_pkg::ITEM_Q1: itemNext = gftd_pkg::ITEM_TP;
      gftd_pkg::ITEM_TP: itemNext = cfgReg.steam ? gftd_pkg::ITEM_SWH : gftd_pkg::ITEM_Q0;
      default: itemNext = gftd_pkg::ITEM_Q0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      itemReg <= gftd_pkg::ITEM_Q0;
      showTotalReg <= 1'b0;
    end else if (keys.rateKey) begin
      itemReg <= defItem;
      showTotalReg <= 1'b0;
    end else if (keys.totalKey) begin
      itemReg <= defItem;
      showTotalReg <= 1'b1;
    end else if (keys.dispKey) begin
      itemReg <= itemNext;
    end else if (timedOut) begin
      itemReg <= defItem;
    end
  end

  // timer restarts whenever a new item is brought up
  always_ff @(posedge clk) begin
    if (!rst_n || keys.rateKey || keys.totalKey || keys.dispKey || itemReg == defItem) begin
      dispTimerReg <= 32'h0;
    end else if (!timedOut) begin
      dispTimerReg <= dispTimerReg + 32'h1;
    end
  end

  assign clearTotals = keys.resetKey && !cfgReg.resetDisable && showTotalReg &&
                       (itemReg == gftd_pkg::ITEM_Q0 || itemReg == gftd_pkg::ITEM_Q1);
  assign displayItem = itemReg;
  assign displayTotal = showTotalReg;

  // ==========================================================
  // scaled pulse output
  gftd_pkg::gftd_pulse_t pulseStReg;
  logic [31:0] pulseCntReg;
  logic [15:0] pendingReg;
  logic [16:0] pendSum;
  logic take;

  assign take = (pulseStReg == gftd_pkg::PULSE_IDLE) && (pendingReg != 16'h0);
  assign pendSum = 17'(pendingReg) + 17'(cfgReg.defaultQty ? advance[1] : advance[0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pendingReg <= 16'h0;
    end else if (pendSum > 17'hffff) begin
      pendingReg <= take ? 16'hfffe : 16'hffff;
    end else begin
      pendingReg <= pendSum[15:0] - (take ? 16'h1 : 16'h0);
    end
  end

  // the gap keeps the rate under 50 pulses per second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulseStReg <= gftd_pkg::PULSE_IDLE;
      pulseCntReg <= 32'h0;
      pulseOutN <= 1'b1;
    end else begin
      case (pulseStReg)
        gftd_pkg::PULSE_IDLE: begin
          if (take) begin
            pulseStReg <= gftd_pkg::PULSE_LOW;
            pulseCntReg <= 32'h0;
            pulseOutN <= 1'b0;
          end
        end
        gftd_pkg::PULSE_LOW: begin
          pulseCntReg <= pulseCntReg + 32'h1;
          if (pulseCntReg == 32'(PulseCyc - 1)) begin
            pulseStReg <= gftd_pkg::PULSE_GAP;
            pulseCntReg <= 32'h0;
            pulseOutN <= 1'b1;
          end
        end
        gftd_pkg::PULSE_GAP: begin
          pulseCntReg <= pulseCntReg + 32'h1;
          if (pulseCntReg == 32'(GapCyc - 1)) begin
            pulseStReg <= gftd_pkg::PULSE_IDLE;
          end
        end
        default: begin
          pulseStReg <= gftd_pkg::PULSE_IDLE;
          pulseOutN <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        gftd_pkg::REG_CFG: regRdata <= {18'h0, cfgReg};
        gftd_pkg::REG_KFACTOR: regRdata <= kFactorReg;
        gftd_pkg::REG_SPAN1: regRdata <= span1Reg;
        gftd_pkg::REG_SPAN2: regRdata <= span2Reg;
        gftd_pkg::REG_MOLWT: regRdata <= molWtReg;
        gftd_pkg::REG_BASE_T: regRdata <= baseTReg;
        gftd_pkg::REG_BASE_P: regRdata <= basePReg;
        gftd_pkg::REG_BASE_Z: regRdata <= baseZReg;
        gftd_pkg::REG_ALARM_HI: regRdata <= alarmHiReg;
        gftd_pkg::REG_ALARM_LO: regRdata <= alarmLoReg;
        gftd_pkg::REG_RATE0: regRdata <= qRate[0];
        gftd_pkg::REG_RATE1: regRdata <= qRate[1];
        gftd_pkg::REG_TOTAL0: regRdata <= {5'h0, totalReg[0]};
        gftd_pkg::REG_TOTAL1: regRdata <= {5'h0, totalReg[1]};
        gftd_pkg::REG_STATUS: regRdata <= {24'h0, useTx1, pendingReg != 16'h0, alarmLow,
                                           alarmHigh, pulseOutN, showTotalReg, itemReg};
        gftd_pkg::REG_SG: regRdata <= sgReg;
        gftd_pkg::REG_DENSITY: regRdata <= rhoBReg;
        default: regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

endmodule : gftd_totalizer
